// file: rtl/frx_pkg.sv
/*
  Shared constants for the receive packet qualifier: register indices,
  field positions, reset values and timing counts.
  Assumes an AHB-Lite register bus with one 32-bit word per register.
*/
package frx_pkg;
	// Register indices; byte address is index times four
	localparam logic [11:0] IDX_PKT_CFG   = 12'h108;
	localparam logic [11:0] IDX_SYNC_LO   = 12'h10C;
	localparam logic [11:0] IDX_SYNC_MID  = 12'h10D;
	localparam logic [11:0] IDX_SYNC_HI   = 12'h10E;
	localparam logic [11:0] IDX_SYNC_CFG  = 12'h10F;
	localparam logic [11:0] IDX_DM_CFG_A  = 12'h305;
	localparam logic [11:0] IDX_RATE_HI   = 12'h30E;
	localparam logic [11:0] IDX_RATE_LO   = 12'h30F;
	localparam logic [11:0] IDX_DM_CFG_B  = 12'h38B;
	localparam logic [11:0] IDX_AFC_CFG   = 12'h3F7;
	localparam logic [11:0] IDX_AFC_READ  = 12'h3FA;
	// Locally placed registers
	localparam logic [11:0] IDX_IRQ_A_EN  = 12'h100;
	localparam logic [11:0] IDX_IRQ_B_EN  = 12'h101;
	localparam logic [11:0] IDX_RX_BASE   = 12'h110;
	localparam logic [11:0] IDX_PAY_LEN   = 12'h111;
	localparam logic [11:0] IDX_STATUS    = 12'h112;
	localparam logic [11:0] IDX_AFC_RANGE = 12'h3F8;
	localparam logic [11:0] IDX_LOOP_GAIN = 12'h3F9;

	// Field positions
	localparam int CRC_OFF_BIT  = 0;
	localparam int SYNC_LEN_LSB = 0;
	localparam int SYNC_TOL_LSB = 5;
	localparam int IRQ_SYNC_BIT = 0;
	localparam int IRQ_PKT_BIT  = 1;
	localparam int KP_LSB       = 0;
	localparam int KI_LSB       = 4;

	// Reset values
	localparam logic [7:0]  RST_PKT_CFG   = 8'h00;
	localparam logic [7:0]  RST_SYNC_CFG  = 8'h18;
	localparam logic [7:0]  RST_AFC_CFG   = 8'h00;
	localparam logic [7:0]  RST_LOOP_GAIN = 8'h99;
	localparam logic [7:0]  RST_AFC_RANGE = 8'h50;
	localparam logic [7:0]  RST_PAY_LEN   = 8'h10;
	localparam logic [15:0] RST_RATE      = 16'h0800;

	// Frequency correction modes
	localparam logic [1:0] AFC_MODE_CLEAR = 2'h2;
	localparam logic [1:0] AFC_MODE_AUTO  = 2'h3;

	// Sync search window after preamble, in bits (four bytes)
	localparam logic [5:0] SYNC_WINDOW_BITS = 6'h20;
	// CRC residue check
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [8:0]  CRC_BYTES = 9'h002;
	// Width of the recovery phase accumulator
	localparam int PHASE_W = 16;
endpackage

// file: rtl/frx_sync_if.sv
/*
  Carrier between the packet controller and the sync matcher.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface frx_sync_if;
	logic        bit_val;  // Recovered bit
	logic        bit_stb;  // One pulse per bit period
	logic        clear;    // Flush the history
	logic [23:0] pattern;  // Expected word, high byte on air first
	logic [4:0]  len;      // Bits compared
	logic [1:0]  tol;      // Mismatches accepted
	logic        hit;      // One-cycle match pulse

	modport ctrl    (output bit_val, bit_stb, clear, pattern, len, tol, input hit);
	modport matcher (input bit_val, bit_stb, clear, pattern, len, tol, output hit);
endinterface
`default_nettype wire

// file: rtl/frx_sync_match.sv
/*
  Sliding sync word matcher with programmable length and error tolerance.
  Assumes bit strobes come at most once per clock from the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module frx_sync_match (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Controller side
	frx_sync_if.matcher sif
);
	typedef struct packed {
		logic [23:0] hist;   // Newest bit at position zero
		logic [4:0]  seen;   // Bits since flush, saturating
		logic        hit;    // Registered match pulse
	} frx_match_st_t;

	frx_match_st_t s_q;   // Current state
	frx_match_st_t s_d;   // Next state
	logic [23:0]   nhist; // History including this bit
	logic [4:0]    errs;  // Mismatch count
	logic [4:0]    want;  // Effective length, zero read as one

	// Next state: shift, count mismatches, compare with tolerance
	always_comb begin
		s_d   = s_q;
		want  = (sif.len == 5'h00) ? 5'h01 : sif.len;
		nhist = {s_q.hist[22:0], sif.bit_val};
		errs  = 5'h00;
		// Only the newest len bits against the pattern's low bits
		for (int i = 0; i < 24; i++) begin
			if ((5'(i) < want) && (nhist[i] != sif.pattern[i])) begin
				errs = errs + 5'h01;
			end
		end
		s_d.hit = 1'b0;
		if (sif.clear) begin
			s_d.hist = 24'h0000_00;
			s_d.seen = 5'h00;
		end else if (sif.bit_stb) begin
			s_d.hist = nhist;
			if (s_q.seen != 5'h1F) begin
				s_d.seen = s_q.seen + 5'h01;
			end
			// Needs a full window first so stale bits never match; the
			// count is compared before the increment so saturation cannot wrap
			if ((s_q.seen >= want - 5'h01) && (errs <= {3'h0, sif.tol})) begin
				s_d.hit = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sif.hit = s_q.hit;
endmodule
`default_nettype wire

// file: rtl/frx_top.sv
/*
  Receive packet qualifier for a GFSK/FSK radio: bit recovery, sync
  search, payload storage, CRC check, frequency correction loop and
  an AHB-Lite register file.
  Assumes demodulator samples, frequency error and preamble flags come
  from logic on hclk; packet RAM takes a write per cycle.
*/
// The implementer's own choice: the AHB-Lite register port.
// Behaviour
// - Pattern in three bytes, high byte first
// - Compare one to twenty-four sync bits
// - Accept when mismatches within tolerance field
// - Sync event to enabled interrupt lines
// - Payload written to RAM from base
// - Sync word never stored
// - CRC checked unless disable bit set
// - Good CRC raises enabled packet interrupt
// - CRC disabled: store CRC, no packet event
// - Bit from comparing two correlator levels
// - Correction PI loop whenever enabled and unlocked
// - Lock on preamble, release without sync
// - Mode three locks automatically on preamble
// - Error readback frozen while locked
// - Correction persists; range zero mode two clears
// - Correction clamped to range in kHz
// - Recovery rate from high and low bytes
// - Rate error tolerated on alternating preamble
// - Fast bit lock within few transitions
// - Sync search four bytes, then release locks
`timescale 1ns/10ps
`default_nettype none
module frx_top #(
	parameter int RAM_AW = 8  // Packet RAM address width
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Demodulator
	input  wire logic              sample_valid,
	input  wire logic [7:0]        corr_level_a,
	input  wire logic [7:0]        corr_level_b,
	input  wire logic              freq_err_valid,
	input  wire logic [7:0]        freq_err_in,
	// Preamble block
	input  wire logic              preamble_detected,
	input  wire logic              preamble_qualified,
	// Packet RAM
	output logic                   ram_we,
	output logic      [RAM_AW-1:0] ram_addr,
	output logic      [7:0]        ram_wdata,
	// Events and radio control
	output logic                   irq_line_a,
	output logic                   irq_line_b,
	output logic                   afc_locked,
	output logic                   lock_release,
	output logic      [15:0]       afc_correction,
	output logic      [6:0]        correlator_bandwidth,
	output logic      [7:0]        post_filter_bandwidth
);
	typedef enum logic [1:0] {ST_HUNT, ST_SYNC, ST_DATA} frx_state_t;

	typedef struct packed {
		// Bus data phase
		logic              wr_pend;   // Write pending
		logic [11:0]       wr_idx;    // Write register index
		logic [31:0]       rdata;     // Read data
		// Registers
		logic [7:0]        pkt_cfg;
		logic [23:0]       sync_pat;
		logic [7:0]        sync_cfg;
		logic [7:0]        dm_a;
		logic [15:0]       rate;
		logic [7:0]        dm_b;
		logic [7:0]        afc_cfg;
		logic [7:0]        afc_read;
		logic [7:0]        afc_range;
		logic [7:0]        loop_gain;
		logic [7:0]        en_a;
		logic [7:0]        en_b;
		logic [RAM_AW-1:0] rx_base;
		logic [7:0]        pay_len;
		logic              last_crc_ok;
		// Bit recovery
		logic [15:0]       phase;
		logic              last_dec;
		// Packet controller
		frx_state_t        state;
		logic [5:0]        win;       // Bits into sync window
		logic [2:0]        bitn;      // Bit in byte
		logic [7:0]        shreg;     // Byte assembly
		logic [8:0]        bytes;     // Bytes after sync
		logic [15:0]       crc;
		// Frequency correction
		logic              locked;
		logic [15:0]       integ;
		logic [15:0]       corr;
		// Outputs
		logic              we;
		logic [RAM_AW-1:0] waddr;
		logic [7:0]        wdata;
		logic              irq_a;
		logic              irq_b;
		logic              rel;
	} frx_st_t;

	frx_st_t     s_q;        // Current state
	frx_st_t     s_d;        // Next state
	frx_sync_if  sif ();     // Link to matcher
	logic        addr_ok;    // Valid address phase
	logic [11:0] a_idx;      // Address phase index
	logic        dec;        // Correlator decision
	logic [16:0] psum;       // Phase step
	logic        bstb;       // Bit centre strobe
	logic        ev_sync;    // Sync event
	logic        ev_pkt;     // Packet event
	logic        nbit;       // CRC feedback
	logic [7:0]  nbyte;      // Completed byte
	logic [12:0] ki_term;    // Integral product
	logic [12:0] kp_term;    // Proportional product
	logic [15:0] raw;        // Unclamped correction
	logic [15:0] lim;        // Clamp limit

	frx_sync_match u_match (
		.hclk    (hclk),
		.hresetn (hresetn),
		.sif     (sif)
	);

	// Register read mux; unmapped reads give zero
	function automatic logic [31:0] rd_reg(input frx_st_t s, input logic [11:0] i);
		logic [7:0] v;
		v = 8'h00;
		case (i)
			frx_pkg::IDX_PKT_CFG:   v = s.pkt_cfg;
			frx_pkg::IDX_SYNC_LO:   v = s.sync_pat[7:0];
			frx_pkg::IDX_SYNC_MID:  v = s.sync_pat[15:8];
			frx_pkg::IDX_SYNC_HI:   v = s.sync_pat[23:16];
			frx_pkg::IDX_SYNC_CFG:  v = {1'b0, s.sync_cfg[6:0]};
			frx_pkg::IDX_DM_CFG_A:  v = {1'b0, s.dm_a[6:0]};
			frx_pkg::IDX_RATE_HI:   v = s.rate[15:8];
			frx_pkg::IDX_RATE_LO:   v = s.rate[7:0];
			frx_pkg::IDX_DM_CFG_B:  v = s.dm_b;
			frx_pkg::IDX_AFC_CFG:   v = s.afc_cfg;
			frx_pkg::IDX_AFC_READ:  v = s.afc_read;
			frx_pkg::IDX_AFC_RANGE: v = s.afc_range;
			frx_pkg::IDX_LOOP_GAIN: v = s.loop_gain;
			frx_pkg::IDX_IRQ_A_EN:  v = s.en_a;
			frx_pkg::IDX_IRQ_B_EN:  v = s.en_b;
			frx_pkg::IDX_RX_BASE:   v = 8'(s.rx_base);
			frx_pkg::IDX_PAY_LEN:   v = s.pay_len;
			frx_pkg::IDX_STATUS:    v = {4'h0, s.last_crc_ok, s.locked, 2'(s.state)};
			default:                v = 8'h00;
		endcase
		return {24'h0000_00, v};
	endfunction

	// Matcher feed
	assign sif.bit_val = dec;
	assign sif.bit_stb = bstb && (s_q.state == ST_SYNC);
	assign sif.clear   = (s_q.state != ST_SYNC);
	assign sif.pattern = s_q.sync_pat;
	assign sif.len     = s_q.sync_cfg[frx_pkg::SYNC_LEN_LSB +: 5];
	assign sif.tol     = s_q.sync_cfg[frx_pkg::SYNC_TOL_LSB +: 2];

	// Bus decode and combinational helpers
	always_comb begin
		a_idx   = haddr[13:2];
		addr_ok = hsel && hready && htrans[1];
		// Bit is whichever correlator is stronger
		dec     = $signed(corr_level_a) > $signed(corr_level_b);
		psum    = {1'b0, s_q.phase} + {1'b0, s_q.rate};
		// Strobe when the phase crosses the bit centre
		bstb    = sample_valid && !s_q.phase[15] && psum[15];
		ev_sync = sif.hit && (s_q.state == ST_SYNC);
		nbit    = s_q.crc[15] ^ dec;
		nbyte   = {s_q.shreg[6:0], dec};
		ki_term = 13'($signed(freq_err_in) * $signed({1'b0, s_q.loop_gain[frx_pkg::KI_LSB +: 4]}));
		kp_term = 13'($signed(freq_err_in) * $signed({1'b0, s_q.loop_gain[frx_pkg::KP_LSB +: 4]}));
		raw     = 16'($signed(s_q.integ) >>> 4) + 16'($signed(kp_term) >>> 2);
		lim     = {8'h00, s_q.afc_range};
		ev_pkt  = 1'b0;
		if (bstb && (s_q.state == ST_DATA) && (s_q.bitn == 3'h7)
		    && (s_q.bytes + 9'h001 == {1'b0, s_q.pay_len} + frx_pkg::CRC_BYTES)
		    && !s_q.pkt_cfg[frx_pkg::CRC_OFF_BIT]) begin
			// Residue zero over payload and CRC
			ev_pkt = ({s_q.crc[14:0], 1'b0} ^ (nbit ? frx_pkg::CRC_POLY : 16'h0000)) == 16'h0000;
		end
	end

	// Next state of everything
	always_comb begin
		s_d       = s_q;
		s_d.we    = 1'b0;
		s_d.rel   = 1'b0;
		s_d.irq_a = 1'b0;
		s_d.irq_b = 1'b0;

		// Bus: register address phase, write in data phase
		s_d.wr_pend = addr_ok && hwrite;
		if (addr_ok) begin
			s_d.wr_idx = a_idx;
			s_d.rdata  = hwrite ? 32'h0000_0000 : rd_reg(s_q, a_idx);
		end
		if (s_q.wr_pend) begin
			case (s_q.wr_idx)
				frx_pkg::IDX_PKT_CFG:   s_d.pkt_cfg = hwdata[7:0];
				frx_pkg::IDX_SYNC_LO:   s_d.sync_pat[7:0] = hwdata[7:0];
				frx_pkg::IDX_SYNC_MID:  s_d.sync_pat[15:8] = hwdata[7:0];
				frx_pkg::IDX_SYNC_HI:   s_d.sync_pat[23:16] = hwdata[7:0];
				frx_pkg::IDX_SYNC_CFG:  s_d.sync_cfg = {1'b0, hwdata[6:0]};
				frx_pkg::IDX_DM_CFG_A:  s_d.dm_a = {1'b0, hwdata[6:0]};
				frx_pkg::IDX_RATE_HI:   s_d.rate[15:8] = hwdata[7:0];
				frx_pkg::IDX_RATE_LO:   s_d.rate[7:0] = hwdata[7:0];
				frx_pkg::IDX_DM_CFG_B:  s_d.dm_b = hwdata[7:0];
				frx_pkg::IDX_AFC_CFG:   s_d.afc_cfg = hwdata[7:0];
				frx_pkg::IDX_AFC_RANGE: s_d.afc_range = hwdata[7:0];
				frx_pkg::IDX_LOOP_GAIN: s_d.loop_gain = hwdata[7:0];
				frx_pkg::IDX_IRQ_A_EN:  s_d.en_a = hwdata[7:0];
				frx_pkg::IDX_IRQ_B_EN:  s_d.en_b = hwdata[7:0];
				frx_pkg::IDX_RX_BASE:   s_d.rx_base = hwdata[RAM_AW-1:0];
				frx_pkg::IDX_PAY_LEN:   s_d.pay_len = hwdata[7:0];
				default:                s_d.rx_base = s_q.rx_base; // Ignored
			endcase
		end

		// Bit recovery: transitions pull the phase to the bit edge, so
		// the loop locks on the first edges of an alternating preamble
		if (sample_valid) begin
			s_d.last_dec = dec;
			if (dec != s_q.last_dec) begin
				s_d.phase = s_q.rate;
			end else begin
				s_d.phase = psum[15:0];
			end
		end

		// Packet controller
		case (s_q.state)
			ST_HUNT: begin
				if (preamble_qualified) begin
					s_d.state = ST_SYNC;
					s_d.win   = 6'h00;
				end
			end
			ST_SYNC: begin
				if (ev_sync) begin
					// Sync bits are consumed here and never stored
					s_d.state = ST_DATA;
					s_d.bitn  = 3'h0;
					s_d.bytes = 9'h000;
					s_d.crc   = frx_pkg::CRC_INIT;
					s_d.irq_a = s_q.en_a[frx_pkg::IRQ_SYNC_BIT];
					s_d.irq_b = s_q.en_b[frx_pkg::IRQ_SYNC_BIT];
				end else if (bstb) begin
					s_d.win = s_q.win + 6'h01;
					if (s_q.win + 6'h01 == frx_pkg::SYNC_WINDOW_BITS) begin
						// Window spent: drop locks, hunt again
						s_d.state = ST_HUNT;
						s_d.rel   = 1'b1;
					end
				end
			end
			ST_DATA: begin
				if (bstb) begin
					s_d.shreg = nbyte;
					s_d.bitn  = s_q.bitn + 3'h1;
					s_d.crc   = {s_q.crc[14:0], 1'b0} ^ (nbit ? frx_pkg::CRC_POLY : 16'h0000);
					if (s_q.bitn == 3'h7) begin
						s_d.bytes = s_q.bytes + 9'h001;
						// CRC bytes kept only when checking is off
						if (s_q.pkt_cfg[frx_pkg::CRC_OFF_BIT] || (s_q.bytes < {1'b0, s_q.pay_len})) begin
							s_d.we    = 1'b1;
							s_d.waddr = s_q.rx_base + RAM_AW'(s_q.bytes);
							s_d.wdata = nbyte;
						end
						if (s_q.bytes + 9'h001 == {1'b0, s_q.pay_len} + frx_pkg::CRC_BYTES) begin
							s_d.state       = ST_HUNT;
							s_d.last_crc_ok = ev_pkt;
							s_d.irq_a       = ev_pkt && s_q.en_a[frx_pkg::IRQ_PKT_BIT];
							s_d.irq_b       = ev_pkt && s_q.en_b[frx_pkg::IRQ_PKT_BIT];
						end
					end
				end
			end
			default: s_d.state = ST_HUNT;
		endcase

		// Frequency correction lock: preamble locks in auto mode, kept
		// through sync and payload, dropped at packet end or on a failed sync search
		if (s_q.afc_cfg[1:0] == frx_pkg::AFC_MODE_AUTO) begin
			if (preamble_detected && s_q.state == ST_HUNT) begin
				s_d.locked = 1'b1;
			end
			if (s_d.rel || (s_q.state == ST_DATA && s_d.state == ST_HUNT)) begin
				s_d.locked = 1'b0;
			end
		end else begin
			s_d.locked = 1'b0;
		end

		// PI loop runs only while enabled and unlocked; only mode three ever locks
		if (freq_err_valid && !s_q.locked && s_q.afc_cfg[1:0] != 2'h0) begin
			s_d.afc_read = freq_err_in;
			s_d.integ    = s_q.integ + 16'($signed(ki_term));
			if ($signed(raw) > $signed(lim)) begin
				s_d.corr = lim;
			end else if ($signed(raw) < -$signed(lim)) begin
				s_d.corr = 16'(-$signed(lim));
			end else begin
				s_d.corr = raw;
			end
		end
		// Correction otherwise holds across states until cleared
		if (s_q.afc_cfg[1:0] == frx_pkg::AFC_MODE_CLEAR && s_q.afc_range == 8'h00) begin
			s_d.integ = 16'h0000;
			s_d.corr  = 16'h0000;
		end
	end

	// State register with documented reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q           <= '0;
			s_q.state     <= ST_HUNT;
			s_q.pkt_cfg   <= frx_pkg::RST_PKT_CFG;
			s_q.sync_cfg  <= frx_pkg::RST_SYNC_CFG;
			s_q.afc_cfg   <= frx_pkg::RST_AFC_CFG;
			s_q.loop_gain <= frx_pkg::RST_LOOP_GAIN;
			s_q.afc_range <= frx_pkg::RST_AFC_RANGE;
			s_q.pay_len   <= frx_pkg::RST_PAY_LEN;
			s_q.rate      <= frx_pkg::RST_RATE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; slave never waits and never errors
	assign hrdata                = s_q.rdata;
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign ram_we                = s_q.we;
	assign ram_addr              = s_q.waddr;
	assign ram_wdata             = s_q.wdata;
	assign irq_line_a            = s_q.irq_a;
	assign irq_line_b            = s_q.irq_b;
	assign afc_locked            = s_q.locked;
	assign lock_release          = s_q.rel;
	assign afc_correction        = s_q.corr;
	assign correlator_bandwidth  = s_q.dm_a[6:0];
	assign post_filter_bandwidth = s_q.dm_b;
endmodule
`default_nettype wire

// file: bench/frx_radio_model.sv
/*
  Far-end transmitter model: drives correlator levels, 32 samples a bit.
  Assumes the bench calls send from one thread only.
*/
`timescale 1ns/10ps
`default_nettype none
module frx_radio_model (
	// Clock
	input  wire logic       hclk,
	// Demodulator stream
	output logic            sample_valid,
	output logic      [7:0] corr_level_a,
	output logic      [7:0] corr_level_b
);
	logic busy;  // High while a byte is on air

	initial begin
		busy = 1'b0;
		sample_valid = 1'b0;
		corr_level_a = 8'h00;
		corr_level_b = 8'h00;
	end

	// Idle level a wanders so no stale decision looks valid
	always @(posedge hclk) begin
		if (!busy) begin
			corr_level_a <= ~corr_level_a;
		end
	end

	// One byte, high bit first; alternating bytes give a clean preamble
	task automatic send(input logic [7:0] d);
		busy = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			repeat (32) begin
				@(posedge hclk);
				sample_valid <= 1'b1;
				corr_level_a <= d[i] ? 8'h40 : 8'hC0;
				corr_level_b <= d[i] ? 8'hC0 : 8'h40;
			end
		end
		@(posedge hclk);
		sample_valid <= 1'b0;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: bench/frx_top_checker.sv
/*
  Port assertions for the receive qualifier.
  Assumes one clock domain; bound into every frx_top.
*/
`timescale 1ns/10ps
`default_nettype none
module frx_top_checker (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Watched ports
	input  wire logic        sample_valid,
	input  wire logic        preamble_detected,
	input  wire logic        ram_we,
	input  wire logic        irq_line_a,
	input  wire logic        irq_line_b,
	input  wire logic        afc_locked,
	input  wire logic        lock_release,
	input  wire logic [15:0] afc_correction
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_irq_a_pulse: assert property (irq_line_a |=> !irq_line_a)
		else $error("line a event longer than one cycle");
	a_irq_b_pulse: assert property (irq_line_b |=> !irq_line_b)
		else $error("line b event longer than one cycle");
	a_write_from_bit: assert property (ram_we |-> $past(sample_valid))
		else $error("RAM write without a bit sample");
	a_write_gap: assert property (ram_we |=> !ram_we [*7])
		else $error("RAM writes closer than one byte");
	a_release_pulse: assert property (lock_release |=> !lock_release)
		else $error("lock release longer than one cycle");
	a_release_unlock: assert property (lock_release |-> ##[0:1] !afc_locked)
		else $error("lock held after release");
	a_lock_cause: assert property ($rose(afc_locked)
		|-> $past(preamble_detected) || $past(preamble_detected, 2))
		else $error("lock without preamble");
	a_hold_corr: assert property (afc_locked && $past(afc_locked)
		|-> $stable(afc_correction))
		else $error("correction moved while locked");

	// Main scenarios reached
	c_sync: cover property (irq_line_b);
	c_write: cover property (ram_we);
	c_release: cover property (lock_release);
endmodule

bind frx_top frx_top_checker u_chk (
	.hclk              (hclk),
	.hresetn           (hresetn),
	.sample_valid      (sample_valid),
	.preamble_detected (preamble_detected),
	.ram_we            (ram_we),
	.irq_line_a        (irq_line_a),
	.irq_line_b        (irq_line_b),
	.afc_locked        (afc_locked),
	.lock_release      (lock_release),
	.afc_correction    (afc_correction)
);
`default_nettype wire

// file: bench/frx_top_test.sv
/*
  Self-checking bench: registers over AHB-Lite, then packets on air.
  Assumes frx_pkg, the radio model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module frx_top_test;
	logic        hclk, hresetn, hsel, hwrite, hready, rdy, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        sv, pre_det, pre_qual, we, irq_a, irq_b, locked, rel, fev;
	logic [7:0]  ca, cb, waddr, wdata, pbw, fei;
	logic [6:0]  cbw;
	logic [15:0] corr;
	logic [15:0] wq[$];  // Captured RAM writes
	int          n_mismatch, samples_checked, n_a, n_b, n_rel;

	assign hready = rdy;

	frx_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
		.sample_valid(sv), .corr_level_a(ca), .corr_level_b(cb),
		.freq_err_valid(fev), .freq_err_in(fei),
		.preamble_detected(pre_det), .preamble_qualified(pre_qual),
		.ram_we(we), .ram_addr(waddr), .ram_wdata(wdata),
		.irq_line_a(irq_a), .irq_line_b(irq_b), .afc_locked(locked),
		.lock_release(rel), .afc_correction(corr),
		.correlator_bandwidth(cbw), .post_filter_bandwidth(pbw));

	frx_radio_model radio (.hclk(hclk), .sample_valid(sv),
		.corr_level_a(ca), .corr_level_b(cb));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Event and write monitor
	always @(posedge hclk) begin
		if (we) begin
			wq.push_back({waddr, wdata});
		end
		n_a <= n_a + int'(irq_a);
		n_b <= n_b + int'(irq_b);
		n_rel <= n_rel + int'(rel);
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// One single transfer; waits on ready in both phases
	task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {18'h0_0000, i, 2'b00};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] i, input logic [7:0] d);
		xfer(1'b1, i, {24'h00_0000, d});
	endtask

	task automatic rdc(input logic [11:0] i, input logic [7:0] e);
		xfer(1'b0, i, 32'h0000_0000);
		chk(rd, {24'h00_0000, e});
	endtask

	function automatic logic [15:0] crc16(input logic [15:0] m);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 15; i >= 0; i--) begin
			c = (c[15] ^ m[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
		end
		return c;
	endfunction

	// Reset values, mirrors, read-only and unmapped places
	task automatic t_regs;
		rdc(frx_pkg::IDX_PKT_CFG, frx_pkg::RST_PKT_CFG);
		rdc(frx_pkg::IDX_SYNC_CFG, frx_pkg::RST_SYNC_CFG);
		rdc(frx_pkg::IDX_RATE_HI, frx_pkg::RST_RATE[15:8]);
		rdc(frx_pkg::IDX_RATE_LO, frx_pkg::RST_RATE[7:0]);
		wr(frx_pkg::IDX_DM_CFG_A, 8'hD5);
		wr(frx_pkg::IDX_DM_CFG_B, 8'hC3);
		wr(frx_pkg::IDX_AFC_READ, 8'h5A);
		rdc(frx_pkg::IDX_AFC_READ, 8'h00);
		rdc(12'h7FF, 8'h00);
		chk(32'(cbw), 32'h0000_0055);
		chk(32'(pbw), 32'h0000_00C3);
	endtask

	// Preamble, qualify, sync with flipped low bits, then payload or filler
	task automatic t_pkt(input logic off, input logic [4:0] len, input logic [1:0] tol,
		input int nflip, input logic hit);
		logic [23:0] pat, tx;
		logic [7:0]  pl[4];
		logic [15:0] c;
		int          w0, a0, b0, r0, n;
		pat = 24'hC3_5A96;
		tx = pat ^ ((24'h00_0001 << nflip) - 24'h00_0001);
		c = crc16(16'h1234);
		pl = '{8'h12, 8'h34, c[15:8], c[7:0]};
		n = off ? 4 : 2;
		wr(frx_pkg::IDX_SYNC_HI, pat[23:16]);
		wr(frx_pkg::IDX_SYNC_MID, pat[15:8]);
		wr(frx_pkg::IDX_SYNC_LO, pat[7:0]);
		rdc(frx_pkg::IDX_SYNC_HI, pat[23:16]);
		wr(frx_pkg::IDX_SYNC_CFG, {1'b0, tol, len});
		wr(frx_pkg::IDX_PKT_CFG, {7'h00, off});
		wr(frx_pkg::IDX_IRQ_A_EN, 8'h03);
		wr(frx_pkg::IDX_IRQ_B_EN, 8'h01);
		wr(frx_pkg::IDX_RX_BASE, 8'h20);
		wr(frx_pkg::IDX_PAY_LEN, 8'h02);
		wr(frx_pkg::IDX_AFC_CFG, 8'h03);
		w0 = wq.size();
		a0 = n_a;
		b0 = n_b;
		r0 = n_rel;
		radio.send(8'hAA);
		radio.send(8'hAA);
		@(posedge hclk);
		pre_det <= 1'b1;
		pre_qual <= 1'b1;
		@(posedge hclk);
		pre_det <= 1'b0;
		pre_qual <= 1'b0;
		@(posedge hclk);
		#1 chk(32'(locked), 32'h0000_0001);
		for (int k = 2; k >= 0; k--) begin
			if (k * 8 < int'(len)) radio.send(tx[k*8 +: 8]);
		end
		for (int k = 0; k < 4; k++) begin
			radio.send(hit ? pl[k] : 8'h00);
		end
		repeat (8) @(posedge hclk);
		chk(32'(wq.size() - w0), hit ? 32'(n) : 32'h0000_0000);
		for (int k = 0; k < n && hit; k++) begin
			chk(32'(wq[w0 + k]), {16'h0000, 8'h20 + 8'(k), pl[k]});
		end
		chk(32'(n_b - b0), 32'(hit));
		chk(32'(n_a - a0), 32'(hit) + 32'(hit && !off));
		chk(32'(n_rel - r0), 32'(!hit));
		chk(32'(locked), 32'h0000_0000);
	endtask

	// Correction loop: both clamps, readback, hold while locked, clear
	task automatic t_afc;
		wr(frx_pkg::IDX_LOOP_GAIN, 8'h99);
		wr(frx_pkg::IDX_AFC_RANGE, 8'h05);
		@(posedge hclk);
		fev <= 1'b1;
		fei <= 8'h40;
		repeat (4) @(posedge hclk);
		fev <= 1'b0;
		#1 chk(32'(corr), 32'h0000_0005);
		@(posedge hclk);
		fev <= 1'b1;
		fei <= 8'h80;
		repeat (4) @(posedge hclk);
		fev <= 1'b0;
		#1 chk(32'(corr), 32'h0000_FFFB);
		rdc(frx_pkg::IDX_AFC_READ, 8'h80);
		@(posedge hclk);
		pre_det <= 1'b1;
		@(posedge hclk);
		pre_det <= 1'b0;
		fev <= 1'b1;
		fei <= 8'h40;
		repeat (4) @(posedge hclk);
		fev <= 1'b0;
		#1 chk(32'(locked), 32'h0000_0001);
		chk(32'(corr), 32'h0000_FFFB);
		rdc(frx_pkg::IDX_AFC_READ, 8'h80);
		wr(frx_pkg::IDX_AFC_RANGE, 8'h00);
		wr(frx_pkg::IDX_AFC_CFG, 8'h02);
		rdc(frx_pkg::IDX_AFC_CFG, 8'h02);
		chk(32'(corr), 32'h0000_0000);
	endtask

	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog well beyond four packets
	initial begin
		#500_000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		{hsel, hwrite, pre_det, pre_qual, hresetn, fev} = 6'h00;
		{htrans, hsize, haddr, hwdata, fei} = '0;
		{n_mismatch, samples_checked, n_a, n_b, n_rel} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_pkt(1'b0, 5'd24, 2'd1, 1, 1'b1);
		t_pkt(1'b1, 5'd16, 2'd3, 3, 1'b1);
		t_pkt(1'b0, 5'd24, 2'd2, 2, 1'b1);
		t_pkt(1'b0, 5'd24, 2'd0, 1, 1'b0);
		t_afc();
		stop_test();
	end
endmodule
`default_nettype wire
